/* File: inc/phy_mode_consts.svh */
// Purpose: Constants for the PHY operating-mode sequencer
// Assumes: 50 MHz core clock
// Notes:   Offsets are byte addresses on the AXI4-Lite slave
`ifndef PHY_MODE_CONSTS_SVH
`define PHY_MODE_CONSTS_SVH

// ****************************************
// Register map
// ****************************************
`define REG_MODE_CTRL    4'h0
`define REG_CONFIG       4'h4
`define REG_STATUS       4'h8
`define REG_FLAGS        4'hc

// ****************************************
// Mode command codes
// ****************************************
`define CMD_STANDBY      4'hc
`define CMD_NORMAL       4'h3
`define CMD_SLEEP_REQ    4'hb

// ****************************************
// Config bit positions
// ****************************************
`define CFG_AUTONOMOUS_OP      0
`define CFG_IDLE_PD      1
`define CFG_LPS_RESP     2
`define CFG_FWD          3
`define CFG_WAKE_CMD     4
`define CFG_LINK_EN      5
`define CFG_MASTER       6
`define CFG_CLK_KEEP     7
`define CFG_FORCE_SLEEP  8
`define CFG_RESET_VAL    9'h000

// ****************************************
// Timing, figures as printed
// ****************************************
`define CLK_MHZ          50
`define T_INIT_US        2000
`define T_STAB_US        2000
`define LPS_MIN_COUNT    8'h08

`endif

/* File: inc/phy_mode_pkg.sv */
// Purpose: Types for the PHY operating-mode sequencer
// Assumes: Included after phy_mode_consts.svh
// Notes:   One-hot mode encoding
package phy_mode_pkg;

  typedef enum logic [6:0] {
    MODE_POWEROFF = 7'h01,
    MODE_STANDBY  = 7'h02,
    MODE_NORMAL   = 7'h04,
    MODE_SLEEPREQ = 7'h08,
    MODE_SILENT   = 7'h10,
    MODE_SLEEP    = 7'h20,
    MODE_INIT     = 7'h40
  } mode_t;

  typedef struct packed {
    logic lps_rx;
    logic wur_rx;
    logic line_active;
    logic wake_pin;
    logic frame_act;
    logic supplies_ok;
    logic uv_det;
    logic bat_ok;
  } line_in_t;

  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic pll_en;
    logic lps_tx;
    logic idle_tx;
    logic link_ready;
    logic clk_out_en;
    logic inhibit;
  } phy_ctl_t;

endpackage

/* File: core/mode_timer.sv */
// Purpose: Terminal-count timer for mode timeouts
// Assumes: Single clock domain
// Notes:   Restarts on start_in; done holds until restart or clear
`timescale 1ns/100ps
module mode_timer #(
  parameter int W = 24
) (
  input  wire logic         mclk_in,
  input  wire logic         reset_n_in,
  input  wire logic         start_in,
  input  wire logic         run_in,
  input  wire logic [W-1:0] limit_in,
  output logic              done_out
);
  logic [W-1:0] cnt_r;
  logic         done_r;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (start_in || !run_in) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      cnt_r  <= cnt_r + 1'b1;
      done_r <= (cnt_r + 1'b1) >= limit_in;
    end
  end

  assign done_out = done_r;
endmodule

/* File: core/phy_mode_fsm.sv */
// Purpose: Operating-mode sequencer of a single-pair Ethernet PHY
// Assumes: Line status inputs are synchronous to mclk_in
// Notes:   Registers reached over AXI4-Lite; timeouts are parameters
`timescale 1ns/100ps
`include "phy_mode_consts.svh"

// Function
// - Command 0xb starts sleep handshake from Normal
// - Idle timeout with power-down enable requests sleep
// - Partner LPS with response enable requests sleep
// - Normal command aborts Sleep Request
// - Wake-request symbols or forwarded wake abort request
// - Send LPS while in Sleep Request
// - Request timer expiry returns Normal, sets fail
// - Partner-started request waits acknowledge timer first
// - LPS received and enough sent enters Silent
// - Silent disables transmitter, sleeps when line quiet
// - Silent line active too long returns Normal
// - Power-on enters Standby with inhibit asserted
// - Strap initialization up to 2 ms, registers stay accessible
// - Standby disables transceiver; undervoltage forces Standby
// - Normal starts PLL, link ready after 2 ms
// - Link enable on master sends idle pulses
// - Autonomous operation enters Normal by itself
// - Sleep accepts reads, only Standby command writes
// - Line activity or wake pin wakes from Sleep
// - Config kept in Sleep; Standby may sleep directly
// - Clock keep-alive holds clock and inhibit in Sleep
// - Forced shutdown enters full Sleep immediately
// - Undervoltage after arming sleeps after timeout
module phy_mode_fsm
  import phy_mode_pkg::*;
#(
  parameter int TW          = 24,
  parameter int T_REQ_CYC   = 5000000,
  parameter int T_ACK_CYC   = 50000,
  parameter int T_PD_CYC    = 5000000,
  parameter int T_UV_CYC    = 5000000,
  parameter int T_INIT_CYC  = `T_INIT_US * `CLK_MHZ,
  parameter int T_STAB_CYC  = `T_STAB_US * `CLK_MHZ
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire line_in_t    line_in,
  input  wire logic [3:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [3:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  output phy_ctl_t         ctl_out,
  output logic             supply_inhibit_out,
  output logic             init_busy_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mode_t      mode;
    logic [8:0] cfg;
    logic       fail;
    logic       wake_seen;
    logic       ack_phase;
    logic       lps_got;
    logic [7:0] lps_sent;
    logic       uv_armed;
    logic       forced;
    logic       init_done;
    logic       aw_got;
    logic       w_got;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    phy_ctl_t   ctl;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ****************************************
  // Timers
  // ****************************************
  logic req_done;
  logic ack_done;
  logic pd_done;
  logic uv_done;
  logic init_tdone;
  logic stab_done;
  logic in_req;
  logic in_silent;
  logic req_start;

  assign in_req    = (st_r.mode == MODE_SLEEPREQ);
  assign in_silent = (st_r.mode == MODE_SILENT);
  assign req_start = (st_nxt.mode == MODE_SLEEPREQ) && !in_req;

  // Request timer restarts on Silent entry to bound line activity
  mode_timer #(.W(TW)) u_req (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .start_in   (req_start || ((st_nxt.mode == MODE_SILENT) && !in_silent)),
    .run_in     (in_req || in_silent),
    .limit_in   (TW'(T_REQ_CYC)),
    .done_out   (req_done)
  );
  mode_timer #(.W(TW)) u_ack (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .start_in   (req_start),
    .run_in     (in_req && st_r.ack_phase),
    .limit_in   (TW'(T_ACK_CYC)),
    .done_out   (ack_done)
  );
  mode_timer #(.W(TW)) u_pd (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .start_in   (line_in.frame_act),
    .run_in     ((st_r.mode == MODE_NORMAL) && st_r.cfg[`CFG_IDLE_PD]),
    .limit_in   (TW'(T_PD_CYC)),
    .done_out   (pd_done)
  );
  mode_timer #(.W(TW)) u_uv (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .start_in   (1'b0),
    .run_in     (st_r.uv_armed && line_in.uv_det),
    .limit_in   (TW'(T_UV_CYC)),
    .done_out   (uv_done)
  );
  mode_timer #(.W(TW)) u_init (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .start_in   (1'b0),
    .run_in     (st_r.mode == MODE_INIT),
    .limit_in   (TW'(T_INIT_CYC)),
    .done_out   (init_tdone)
  );
  mode_timer #(.W(TW)) u_stab (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .start_in   (1'b0),
    .run_in     (st_r.mode == MODE_NORMAL),
    .limit_in   (TW'(T_STAB_CYC)),
    .done_out   (stab_done)
  );

  // ****************************************
  // Next state
  // ****************************************
  logic        wr_fire;
  logic        rd_fire;
  logic [31:0] wval;
  logic        cmd_wr;
  logic [3:0]  cmd;
  logic        asleep;

  always_comb begin
    st_nxt  = st_r;
    asleep  = (st_r.mode == MODE_SLEEP);
    wval    = st_r.w_data;
    cmd     = st_r.w_data[3:0];
    cmd_wr  = 1'b0;
    wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    rd_fire = arvalid_in && !st_r.rvalid;

    // Bus write channels, taken in either order
    if (awvalid_in && !st_r.aw_got) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = awaddr_in;
    end
    if (wvalid_in && !st_r.w_got) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = wdata_in;
      st_nxt.w_strb = wstrb_in;
    end
    if (wr_fire) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = 2'b00;
      case (st_r.aw_addr)
        `REG_MODE_CTRL: begin
          // Sleep accepts only Standby command
          if (!asleep || cmd == `CMD_STANDBY) cmd_wr = st_r.w_strb[0];
          else st_nxt.bresp = 2'b10;
        end
        `REG_CONFIG: begin
          if (asleep) st_nxt.bresp = 2'b10;
          else begin
            if (st_r.w_strb[0]) st_nxt.cfg[7:0] = wval[7:0];
            if (st_r.w_strb[1]) st_nxt.cfg[8] = wval[8];
          end
        end
        `REG_FLAGS: begin
          if (asleep) st_nxt.bresp = 2'b10;
          else begin
            if (st_r.w_strb[0] && wval[0]) st_nxt.fail = 1'b0;
            if (st_r.w_strb[0] && wval[1]) st_nxt.wake_seen = 1'b0;
          end
        end
        `REG_STATUS: ;
        default: st_nxt.bresp = 2'b10;
      endcase
    end
    if (st_r.bvalid && bready_in) st_nxt.bvalid = 1'b0;

    if (rd_fire) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = 2'b00;
      case (araddr_in)
        `REG_MODE_CTRL: st_nxt.rdata = {25'h0, st_r.mode};
        `REG_CONFIG:    st_nxt.rdata = {23'h0, st_r.cfg};
        `REG_STATUS:    st_nxt.rdata = {22'h0, st_r.lps_sent, st_r.init_done, st_r.ctl.link_ready};
        `REG_FLAGS:     st_nxt.rdata = {30'h0, st_r.wake_seen, st_r.fail};
        default: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rresp = 2'b10;
        end
      endcase
    end
    if (st_r.rvalid && rready_in) st_nxt.rvalid = 1'b0;

    if (line_in.supplies_ok) st_nxt.uv_armed = 1'b1;

    // Mode sequencing
    case (st_r.mode)
      MODE_POWEROFF: begin
        if (line_in.bat_ok) st_nxt.mode = MODE_STANDBY;
      end
      MODE_STANDBY: begin
        if (!st_r.init_done && line_in.supplies_ok) st_nxt.mode = MODE_INIT;
        else if (st_r.init_done && st_r.cfg[`CFG_AUTONOMOUS_OP]) st_nxt.mode = MODE_NORMAL;
        else if (cmd_wr && cmd == `CMD_NORMAL) st_nxt.mode = MODE_NORMAL;
        else if (cmd_wr && cmd == `CMD_SLEEP_REQ) st_nxt.mode = MODE_SLEEP;
      end
      MODE_INIT: begin
        if (init_tdone) begin
          st_nxt.init_done = 1'b1;
          st_nxt.mode      = MODE_STANDBY;
        end
      end
      MODE_NORMAL: begin
        st_nxt.lps_got  = 1'b0;
        st_nxt.lps_sent = 8'h00;
        if (cmd_wr && cmd == `CMD_STANDBY) st_nxt.mode = MODE_STANDBY;
        else if (cmd_wr && cmd == `CMD_SLEEP_REQ) begin
          st_nxt.mode      = MODE_SLEEPREQ;
          st_nxt.ack_phase = 1'b0;
        end else if (pd_done && st_r.cfg[`CFG_IDLE_PD]) begin
          st_nxt.mode      = MODE_SLEEPREQ;
          st_nxt.ack_phase = 1'b0;
        end else if (line_in.lps_rx && st_r.cfg[`CFG_LPS_RESP]) begin
          st_nxt.mode      = MODE_SLEEPREQ;
          st_nxt.ack_phase = 1'b1;
          st_nxt.lps_got   = 1'b1;
        end
      end
      MODE_SLEEPREQ: begin
        if (line_in.lps_rx) st_nxt.lps_got = 1'b1;
        if (st_r.ctl.lps_tx && st_r.lps_sent != `LPS_MIN_COUNT)
          st_nxt.lps_sent = st_r.lps_sent + 8'h01;
        if (cmd_wr && cmd == `CMD_NORMAL) st_nxt.mode = MODE_NORMAL;
        else if (line_in.wur_rx ||
                 (st_r.cfg[`CFG_FWD] && st_r.cfg[`CFG_WAKE_CMD]))
          st_nxt.mode = MODE_NORMAL;
        else if (st_r.lps_got && st_r.lps_sent == `LPS_MIN_COUNT)
          st_nxt.mode = MODE_SILENT;
        else if (req_done) begin
          st_nxt.mode = MODE_NORMAL;
          st_nxt.fail = 1'b1;
        end
      end
      MODE_SILENT: begin
        if (!line_in.line_active) st_nxt.mode = MODE_SLEEP;
        else if (req_done) begin
          st_nxt.mode = MODE_NORMAL;
          st_nxt.fail = 1'b1;
        end
      end
      MODE_SLEEP: begin
        // Config held here, nothing reloads it
        if (line_in.line_active || line_in.wake_pin) begin
          st_nxt.mode      = MODE_STANDBY;
          st_nxt.wake_seen = 1'b1;
        end else if (cmd_wr) st_nxt.mode = MODE_STANDBY;
      end
      default: st_nxt.mode = MODE_POWEROFF;
    endcase

    // Fail-silent and shutdown overrides
    if (st_r.mode != MODE_POWEROFF && st_r.mode != MODE_SLEEP && line_in.uv_det)
      st_nxt.mode = MODE_STANDBY;
    if (uv_done) st_nxt.mode = MODE_SLEEP;
    if (st_r.cfg[`CFG_FORCE_SLEEP]) begin
      st_nxt.mode = MODE_SLEEP;
      st_nxt.cfg[`CFG_FORCE_SLEEP] = 1'b0;
      st_nxt.forced = 1'b1;
    end
    // Forced sleep lasts until a wake, not just one cycle
    if (st_nxt.mode != MODE_SLEEP) st_nxt.forced = 1'b0;

    // Outputs follow registered mode
    st_nxt.ctl.tx_en  = (st_r.mode == MODE_NORMAL) || in_req;
    st_nxt.ctl.rx_en  = (st_r.mode == MODE_NORMAL) || in_req || in_silent;
    st_nxt.ctl.pll_en = (st_r.mode == MODE_NORMAL) || in_req || in_silent;
    st_nxt.ctl.link_ready = (st_r.mode == MODE_NORMAL) && stab_done;
    st_nxt.ctl.idle_tx = (st_r.mode == MODE_NORMAL) && stab_done &&
                         st_r.cfg[`CFG_LINK_EN] && st_r.cfg[`CFG_MASTER];
    st_nxt.ctl.lps_tx = in_req && (!st_r.ack_phase || ack_done);
    // Keep-alive lapses once a forced shutdown lands
    st_nxt.ctl.clk_out_en = !asleep ||
                            (st_r.cfg[`CFG_CLK_KEEP] && !st_r.cfg[`CFG_FORCE_SLEEP] &&
                             !st_r.forced);
    st_nxt.ctl.inhibit = (st_r.mode != MODE_POWEROFF) && st_nxt.ctl.clk_out_en;
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r      <= '0;
      st_r.mode <= MODE_POWEROFF;
      st_r.cfg  <= `CFG_RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign awready_out        = !st_r.aw_got;
  assign wready_out         = !st_r.w_got;
  assign bvalid_out         = st_r.bvalid;
  assign bresp_out          = st_r.bresp;
  assign arready_out        = !st_r.rvalid;
  assign rvalid_out         = st_r.rvalid;
  assign rresp_out          = st_r.rresp;
  assign rdata_out          = st_r.rdata;
  assign ctl_out            = st_r.ctl;
  assign supply_inhibit_out = st_r.ctl.inhibit;
  assign init_busy_out      = (st_r.mode == MODE_INIT);
endmodule

/* File: testbench/phy_mode_fsm_chk.sv */
// Purpose: Port-level assertions for the mode sequencer
// Assumes: One clock, short timeout parameters from the bench
// Notes:   Bound into phy_mode_fsm
`timescale 1ns/100ps
module phy_mode_fsm_chk
  import phy_mode_pkg::*;
(
  input wire logic     mclk_in,
  input wire logic     reset_n_in,
  input wire line_in_t line_in,
  input wire logic     bvalid_out,
  input wire logic     bready_in,
  input wire logic     rvalid_out,
  input wire logic     rready_in,
  input wire phy_ctl_t ctl_out,
  input wire logic     supply_inhibit_out,
  input wire logic     init_busy_out
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  a_inh_init: assert property (init_busy_out |-> supply_inhibit_out)
    else $error("inhibit low during init");
  a_init_quiet: assert property (init_busy_out |-> !ctl_out.tx_en && !ctl_out.rx_en)
    else $error("transceiver on during init");
  a_init_span: assert property ($rose(init_busy_out) |=> init_busy_out [*8])
    else $error("init ended too early");
  a_uv_quiet: assert property (line_in.uv_det && ctl_out.tx_en |-> ##[1:3] !ctl_out.tx_en)
    else $error("transmitter kept on in undervoltage");
  a_stab_wait: assert property ($rose(ctl_out.pll_en) |-> !ctl_out.link_ready [*8])
    else $error("link ready before stabilisation");
  a_pin_wake: assert property (line_in.wake_pin && !supply_inhibit_out
    |-> ##[1:4] supply_inhibit_out)
    else $error("no wake on wake pin");
  a_line_wake: assert property (line_in.line_active && !supply_inhibit_out
    |-> ##[1:4] supply_inhibit_out)
    else $error("no wake on line activity");
  a_bresp_hold: assert property (bvalid_out && !bready_in |=> bvalid_out)
    else $error("write response dropped");
  a_rresp_hold: assert property (rvalid_out && !rready_in |=> rvalid_out)
    else $error("read response dropped");
  cover property ($rose(init_busy_out));
  cover property ($rose(ctl_out.lps_tx));
  cover property ($fell(supply_inhibit_out));
endmodule

bind phy_mode_fsm phy_mode_fsm_chk u_phy_mode_fsm_chk (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .line_in(line_in),
  .bvalid_out(bvalid_out), .bready_in(bready_in), .rvalid_out(rvalid_out),
  .rready_in(rready_in), .ctl_out(ctl_out), .supply_inhibit_out(supply_inhibit_out),
  .init_busy_out(init_busy_out));

/* File: testbench/link_partner_model.sv */
// Purpose: Link partner answering a sleep request
// Assumes: Partner sees the local LPS transmit level
// Notes:   Answers only when told; poke forces line activity
`timescale 1ns/100ps
module link_partner_model (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  input  wire logic lps_tx_in,
  input  wire logic respond_in,
  input  wire logic poke_in,
  output logic      lps_rx_out,
  output logic      active_out
);
  int cnt_r;
  // ****************************************
  // Answer sequence
  // ****************************************
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= 0;
    end else if (cnt_r == 0) begin
      if (lps_tx_in && respond_in) cnt_r <= 1;
    end else if (cnt_r < 30) begin
      cnt_r <= cnt_r + 1;
    end else if (!lps_tx_in) begin
      cnt_r <= 0;
    end
  end
  // Own LPS only after an acknowledge pause
  assign lps_rx_out = (cnt_r > 10) && (cnt_r < 24);
  // Line falls quiet after the answer so the local side may sleep
  assign active_out = lps_rx_out || poke_in;
endmodule

/* File: testbench/ethernet_phy_power_mode_fsm_tb_top.sv */
// Purpose: Self-checking bench for the mode sequencer
// Assumes: Short timeouts set through parameters
// Notes:   Register model kept in cfg_m
`timescale 1ns/100ps
`include "phy_mode_consts.svh"
module ethernet_phy_power_mode_fsm_tb_top
  import phy_mode_pkg::*;
;
  logic mclk_in, reset_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
  logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
  logic init_busy_out, supply_inhibit_out, respond, poke, p_lps, p_act;
  logic bat_ok, sup_ok, uv, wake, wur, frame, lps_inj;
  logic [3:0] awaddr_in, araddr_in, wstrb_in;
  logic [31:0] wdata_in, rdata_out, cfg_m, rng, d;
  logic [1:0] bresp_out, rresp_out, r;
  line_in_t line_in;
  phy_ctl_t ctl_out;
  int failures, n_checks, n;
  assign line_in = {p_lps | lps_inj, wur, p_act, wake, frame, sup_ok, uv, bat_ok};
  phy_mode_fsm #(.T_REQ_CYC(60), .T_ACK_CYC(20), .T_PD_CYC(40), .T_UV_CYC(40),
    .T_INIT_CYC(20), .T_STAB_CYC(20)) u_phy_mode_fsm (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .line_in(line_in), .awaddr_in(awaddr_in),
    .awvalid_in(awvalid_in), .awready_out(awready_out), .wdata_in(wdata_in),
    .wstrb_in(wstrb_in), .wvalid_in(wvalid_in), .wready_out(wready_out),
    .bresp_out(bresp_out), .bvalid_out(bvalid_out), .bready_in(bready_in),
    .araddr_in(araddr_in), .arvalid_in(arvalid_in), .arready_out(arready_out),
    .rdata_out(rdata_out), .rresp_out(rresp_out), .rvalid_out(rvalid_out),
    .rready_in(rready_in), .ctl_out(ctl_out), .supply_inhibit_out(supply_inhibit_out),
    .init_busy_out(init_busy_out));
  link_partner_model u_link_partner_model (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .lps_tx_in(ctl_out.lps_tx), .respond_in(respond), .poke_in(poke),
    .lps_rx_out(p_lps), .active_out(p_act));
  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic timeout(input string s);
    failures++;
    $display("[ERR] %s wait exp done got timeout", s);
    print_verdict();
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic chk_pin(input string s, input logic e, input logic g);
    chk(s, {31'h0, e}, {31'h0, g});
  endtask
  task automatic chk_resp(input string s, input logic [1:0] e, input logic [1:0] g);
    chk(s, {30'h0, e}, {30'h0, g});
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge mclk_in);
    awaddr_in <= a;
    wdata_in <= v;
    awvalid_in <= 1'h1;
    wvalid_in <= 1'h1;
    bready_in <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk_in);
      if (awvalid_in && awready_out) awvalid_in <= 1'h0;
      if (wvalid_in && wready_out) wvalid_in <= 1'h0;
      if (bvalid_out) break;
    end
    rs = bresp_out;
    bready_in <= 1'h0;
    if (k == 50) timeout("write");
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge mclk_in);
    araddr_in <= a;
    arvalid_in <= 1'h1;
    rready_in <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk_in);
      if (arvalid_in && arready_out) arvalid_in <= 1'h0;
      if (rvalid_out) break;
    end
    v = rdata_out;
    rs = rresp_out;
    rready_in <= 1'h0;
    if (k == 50) timeout("read");
  endtask
  task automatic wait_mode(input logic [6:0] e);
    int k;
    logic [31:0] v;
    logic [1:0] rs;
    for (k = 0; k < 60; k++) begin
      rd(`REG_MODE_CTRL, v, rs);
      if (v[6:0] === e) break;
    end
    chk("mode", {25'h0, e}, {25'h0, v[6:0]});
    if (k == 60) timeout("mode");
  endtask
  // ****************************************
  // Clock and sequence
  // ****************************************
  initial begin
    mclk_in = 1'h0;
    forever #10 mclk_in = ~mclk_in;
  end
  initial begin
    {reset_n_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 6'h0;
    {respond, poke, sup_ok, uv, wake, wur, lps_inj} = 7'h0;
    {bat_ok, frame, awaddr_in, araddr_in, wstrb_in} = 14'h100f;
    {wdata_in, failures, n_checks, rng} = {32'h0, 32'h0, 32'h0, 32'h3c};
    repeat (8) @(posedge mclk_in);
    reset_n_in <= 1'h1;
    wait_mode(MODE_POWEROFF);
    chk_pin("inhibit", 1'h0, supply_inhibit_out);
    bat_ok <= 1'h1;
    wait_mode(MODE_STANDBY);
    chk_pin("inhibit", 1'h1, supply_inhibit_out);
    sup_ok <= 1'h1;
    repeat (3) @(posedge mclk_in);
    chk_pin("init_busy", 1'h1, init_busy_out);
    for (n = 0; n < 60 && init_busy_out !== 1'h0; n++) @(posedge mclk_in);
    wait_mode(MODE_STANDBY);
    chk_pin("tx_en", 1'h0, ctl_out.tx_en);
    $display("test power-up done");
    wr(`REG_MODE_CTRL, 32'h3, r);
    wait_mode(MODE_NORMAL);
    chk_pin("pll_en", 1'h1, ctl_out.pll_en);
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    cfg_m = 32'h60 | (rng & 32'h4);
    wr(`REG_CONFIG, cfg_m, r);
    for (n = 0; n < 60 && ctl_out.link_ready !== 1'h1; n++) @(posedge mclk_in);
    chk_pin("idle_tx", 1'h1, ctl_out.idle_tx);
    rd(4'h2, d, r);
    chk_resp("unmapped", 2'h2, r);
    $display("test normal done");
    respond <= 1'h1;
    wr(`REG_MODE_CTRL, 32'hb, r);
    for (n = 0; n < 20 && ctl_out.lps_tx !== 1'h1; n++) @(posedge mclk_in);
    chk_pin("lps_tx", 1'h1, ctl_out.lps_tx);
    wait_mode(MODE_SLEEP);
    chk_pin("inhibit", 1'h0, supply_inhibit_out);
    wr(`REG_CONFIG, 32'h0, r);
    chk_resp("sleep cfg", 2'h2, r);
    poke <= 1'h1;
    wait_mode(MODE_STANDBY);
    poke <= 1'h0;
    rd(`REG_CONFIG, d, r);
    chk("config", cfg_m, d);
    respond <= 1'h0;
    $display("test handshake done");
    wr(`REG_MODE_CTRL, 32'h3, r);
    wr(`REG_MODE_CTRL, 32'hb, r);
    wait_mode(MODE_SLEEPREQ);
    wait_mode(MODE_NORMAL);
    rd(`REG_FLAGS, d, r);
    chk("fail", 32'h1, d & 32'h1);
    wr(`REG_FLAGS, 32'h3, r);
    wr(`REG_MODE_CTRL, 32'hb, r);
    wr(`REG_MODE_CTRL, 32'h3, r);
    wait_mode(MODE_NORMAL);
    rd(`REG_FLAGS, d, r);
    chk("no fail", 32'h0, d & 32'h1);
    wr(`REG_CONFIG, cfg_m | 32'h2, r);
    frame <= 1'h0;
    wait_mode(MODE_SLEEPREQ);
    frame <= 1'h1;
    wr(`REG_MODE_CTRL, 32'h3, r);
    wait_mode(MODE_NORMAL);
    wr(`REG_MODE_CTRL, 32'hb, r);
    wur <= 1'h1;
    wait_mode(MODE_NORMAL);
    wur <= 1'h0;
    rd(`REG_FLAGS, d, r);
    chk("no fail", 32'h0, d & 32'h1);
    uv <= 1'h1;
    wait_mode(MODE_STANDBY);
    uv <= 1'h0;
    $display("test aborts done");
    wr(`REG_CONFIG, cfg_m | 32'h180, r);
    wait_mode(MODE_SLEEP);
    chk_pin("clk_out", 1'h0, ctl_out.clk_out_en);
    chk_pin("inhibit", 1'h0, supply_inhibit_out);
    wake <= 1'h1;
    wait_mode(MODE_STANDBY);
    wake <= 1'h0;
    wr(`REG_CONFIG, cfg_m | 32'h100, r);
    wait_mode(MODE_SLEEP);
    wr(`REG_MODE_CTRL, 32'hc, r);
    chk_resp("standby cmd", 2'h0, r);
    wait_mode(MODE_STANDBY);
    wr(`REG_CONFIG, cfg_m | 32'h80, r);
    wr(`REG_MODE_CTRL, 32'hb, r);
    wait_mode(MODE_SLEEP);
    chk_pin("clk_keep", 1'h1, ctl_out.clk_out_en);
    chk_pin("inhibit", 1'h1, supply_inhibit_out);
    wr(`REG_MODE_CTRL, 32'hc, r);
    wait_mode(MODE_STANDBY);
    $display("test forced sleep done");
    wr(`REG_CONFIG, 32'h5, r);
    wait_mode(MODE_NORMAL);
    lps_inj <= 1'h1;
    @(posedge mclk_in);
    lps_inj <= 1'h0;
    wait_mode(MODE_SLEEPREQ);
    chk_pin("lps_tx", 1'h0, ctl_out.lps_tx);
    for (n = 0; n < 40 && ctl_out.lps_tx !== 1'h1; n++) @(posedge mclk_in);
    chk_pin("lps_tx", 1'h1, ctl_out.lps_tx);
    wait_mode(MODE_SLEEP);
    $display("test partner request done");
    print_verdict();
  end
endmodule
